// ### hdl/gp_port.sv
// Purpose: six-pin bidirectional port with a shared pin-change flag
// Assumes: core drives io_req for one cycle per access; pins are pads
// Notes: read data appears one cycle after the read request
`timescale 1ns/1ns
module gp_port
	import gp_pkg::*;
#(
	parameter int unsigned NPIN = GP_NPIN
) (
	input  wire logic            clk,
	input  wire logic            srst,
	input  wire gp_io_req_t      io_req,
	output logic [7:0]           io_rdata,
	input  wire logic            global_irq_en,
	input  wire logic            irq_ack,
	output logic                 irq_req,
	input  wire logic [NPIN-1:0] pin_i,
	output logic [NPIN-1:0]      pin_o,
	output logic [NPIN-1:0]      pin_oe,
	output logic [NPIN-1:0]      pin_pu
);

	// register state
	logic [7:0]      pin_change_mask_ff;
	logic [7:0]      direction_ff;
	logic [7:0]      output_ff;
	logic            global_pullup_disable_ff;
	logic            pcie_ff;
	logic            pin_change_flag_ff;
	logic [7:0]      rdata_ff;
	logic [NPIN-1:0] prev_ff;

	// next values
	logic [7:0]      nxt_pin_change_mask;
	logic [7:0]      nxt_direction;
	logic [7:0]      nxt_output;
	logic [7:0]      nxt_ccr;
	logic [7:0]      nxt_gimr;
	logic            nxt_flag;
	logic [7:0]      nxt_rdata;

	// decode and datapath helpers
	logic [NPIN-1:0] in_sync;
	logic [NPIN-1:0] change;
	logic [7:0]      toggle;
	logic [7:0]      in_rd;
	logic            flag_set;
	logic            flag_clr;

	// a full write or a bit operation inside the bit-addressable range
	function automatic logic hit(input gp_io_req_t r, input logic [5:0] a);
		logic bitop;
		bitop = (r.bset | r.bclr) & (r.addr < GP_BITOP_LIM);
		return (r.we | bitop) & (r.addr == a);
	endfunction

	// new byte after a full write or a single-bit set or clear
	function automatic logic [7:0] upd(input logic [7:0] cur, input gp_io_req_t r);
		logic [7:0] v;
		v = cur;
		if (r.we) begin
			v = r.wdata;
		end else if (r.bset) begin
			v[r.bidx] = 1'b1;
		end else if (r.bclr) begin
			v[r.bidx] = 1'b0;
		end
		return v;
	endfunction

	// pin level synchroniser feeding the input register
	gp_sync #(
		.W (NPIN)
	) u_sync (
		.clk  (clk),
		.srst (srst),
		.d    (pin_i),
		.q    (in_sync)
	);

	// input register image, unused high bits read zero
	always_comb begin
		in_rd = '0;
		in_rd[NPIN-1:0] = in_sync;
	end

	// write decode for the port registers
	always_comb begin
		nxt_pin_change_mask = pin_change_mask_ff;
		nxt_direction       = direction_ff;
		nxt_output          = output_ff;
		nxt_ccr             = '0;
		nxt_gimr            = '0;
		toggle              = '0;
		nxt_ccr[GP_PUO_BIT]   = global_pullup_disable_ff;
		nxt_gimr[GP_PCIE_BIT] = pcie_ff;
		if (hit(io_req, GP_PCM_ADDR)) begin
			nxt_pin_change_mask = upd(pin_change_mask_ff, io_req);
		end
		if (hit(io_req, GP_DIR_ADDR)) begin
			nxt_direction = upd(direction_ff, io_req);
		end
		if (hit(io_req, GP_OUT_ADDR)) begin
			nxt_output = upd(output_ff, io_req);
		end
		// ones written to the input location flip the output bits
		if (hit(io_req, GP_IN_ADDR)) begin
			toggle = upd(8'h00, io_req);
		end
		nxt_output = nxt_output ^ toggle;
		if (hit(io_req, GP_CCR_ADDR)) begin
			nxt_ccr = upd(nxt_ccr, io_req);
		end
		if (hit(io_req, GP_GIMR_ADDR)) begin
			nxt_gimr = upd(nxt_gimr, io_req);
		end
	end

	// pin-change mask, high bits never stored
	always_ff @(posedge clk) begin
		if (srst) begin
			pin_change_mask_ff <= GP_PCM_RST;
		end else begin
			pin_change_mask_ff <= {2'b00, nxt_pin_change_mask[5:0]};
		end
	end

	// direction and output registers, unused pins kept zero
	always_ff @(posedge clk) begin
		if (srst) begin
			direction_ff <= GP_DIR_RST;
			output_ff    <= GP_OUT_RST;
		end else begin
			direction_ff <= nxt_direction & 8'(2**NPIN - 1);
			output_ff    <= nxt_output & 8'(2**NPIN - 1);
		end
	end

	// control bits: pull-up disable and pin-change enable
	always_ff @(posedge clk) begin
		if (srst) begin
			global_pullup_disable_ff <= GP_PUO_RST;
			pcie_ff                  <= GP_PCIE_RST;
		end else begin
			global_pullup_disable_ff <= nxt_ccr[GP_PUO_BIT];
			pcie_ff                  <= nxt_gimr[GP_PCIE_BIT];
		end
	end

	// previous sampled level tracks even through reset
	always_ff @(posedge clk) begin
		prev_ff <= in_sync;
	end

	// change events, pin direction plays no part
	assign change   = (in_sync ^ prev_ff) & pin_change_mask_ff[NPIN-1:0];
	assign flag_set = |change;
	assign flag_clr = irq_ack
		| (io_req.we & (io_req.addr == GP_IRQF_ADDR) & io_req.wdata[GP_PCF_BIT]);

	// a new event in the clearing cycle keeps the flag set
	always_comb begin
		nxt_flag = pin_change_flag_ff;
		if (flag_set) begin
			nxt_flag = 1'b1;
		end else if (flag_clr) begin
			nxt_flag = 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			pin_change_flag_ff <= GP_PCF_RST;
		end else begin
			pin_change_flag_ff <= nxt_flag;
		end
	end

	// read mux, reserved bits and unmapped locations read zero
	always_comb begin
		nxt_rdata = rdata_ff;
		if (io_req.re) begin
			unique case (io_req.addr)
				GP_PCM_ADDR:  nxt_rdata = pin_change_mask_ff;
				GP_IN_ADDR:   nxt_rdata = in_rd;
				GP_DIR_ADDR:  nxt_rdata = direction_ff;
				GP_OUT_ADDR:  nxt_rdata = output_ff;
				GP_CCR_ADDR:  nxt_rdata = nxt_ccr;
				GP_GIMR_ADDR: nxt_rdata = nxt_gimr;
				GP_IRQF_ADDR: begin
					nxt_rdata = '0;
					nxt_rdata[GP_PCF_BIT] = pin_change_flag_ff;
				end
				default:      nxt_rdata = '0;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			rdata_ff <= GP_RD_RST;
		end else begin
			rdata_ff <= nxt_rdata;
		end
	end

	// pin drive per bit, each pin from its own register bits plus the shared pull-up disable
	genvar gi;
	generate
		for (gi = 0; gi < NPIN; gi++) begin : g_pin
			// reset gates the drivers directly, no clock needed
			assign pin_oe[gi] = direction_ff[gi] & ~srst;
			assign pin_o[gi]  = output_ff[gi];
			assign pin_pu[gi] = ~direction_ff[gi] & output_ff[gi]
				& ~global_pullup_disable_ff & ~srst;
		end
	endgenerate

	assign io_rdata = rdata_ff;
	assign irq_req  = global_irq_en & pcie_ff & pin_change_flag_ff;

	// checks next to the logic above

	property p_flag_set;
		@(posedge clk) disable iff (srst)
		|((in_sync ^ prev_ff) & pin_change_mask_ff[NPIN-1:0])
			|=> pin_change_flag_ff;
	endproperty
	a_flag_set: assert property (p_flag_set)
		else $error("masked pin change did not set the flag");

	property p_flag_ack;
		@(posedge clk) disable iff (srst)
		irq_ack && !(|change) |=> !pin_change_flag_ff;
	endproperty
	a_flag_ack: assert property (p_flag_ack)
		else $error("interrupt entry did not clear the flag");

	property p_flag_w1c;
		@(posedge clk) disable iff (srst)
		io_req.we && io_req.addr == GP_IRQF_ADDR && io_req.wdata[GP_PCF_BIT]
			&& !(|change) |=> !pin_change_flag_ff;
	endproperty
	a_flag_w1c: assert property (p_flag_w1c)
		else $error("writing one did not clear the flag");

	property p_irq_gate;
		@(posedge clk) disable iff (srst)
		irq_req |-> global_irq_en && pin_change_flag_ff && $past(nxt_gimr[GP_PCIE_BIT]);
	endproperty
	a_irq_gate: assert property (p_irq_gate)
		else $error("interrupt requested without all enables and flag");

	property p_mask_reset;
		@(posedge clk) disable iff (srst)
		$past(srst) |-> pin_change_mask_ff == GP_PCM_RST && !pin_change_flag_ff;
	endproperty
	a_mask_reset: assert property (p_mask_reset)
		else $error("mask or flag not zero after reset");

	property p_mask_hi;
		@(posedge clk) disable iff (srst)
		io_req.re && io_req.addr == GP_PCM_ADDR |=> io_rdata[7:6] == 2'b00;
	endproperty
	a_mask_hi: assert property (p_mask_hi)
		else $error("mask register upper bits read non-zero");

	property p_dir_write;
		@(posedge clk) disable iff (srst)
		io_req.we && io_req.addr == GP_DIR_ADDR
			|=> pin_oe == $past(io_req.wdata[NPIN-1:0]);
	endproperty
	a_dir_write: assert property (p_dir_write)
		else $error("driver enables differ from written direction");

	property p_pullup;
		@(posedge clk) disable iff (srst)
		global_pullup_disable_ff || pin_oe != '0 |-> (pin_pu & pin_oe) == '0
			&& (!global_pullup_disable_ff || pin_pu == '0);
	endproperty
	a_pullup: assert property (p_pullup)
		else $error("pull-up active on an output or while disabled");

	property p_out_write;
		@(posedge clk) disable iff (srst)
		io_req.we && io_req.addr == GP_OUT_ADDR
			|=> pin_o == $past(io_req.wdata[NPIN-1:0]);
	endproperty
	a_out_write: assert property (p_out_write)
		else $error("pin level differs from written output bits");

	property p_toggle;
		@(posedge clk) disable iff (srst)
		io_req.we && io_req.addr == GP_IN_ADDR
			|=> pin_o == ($past(pin_o) ^ $past(io_req.wdata[NPIN-1:0]));
	endproperty
	a_toggle: assert property (p_toggle)
		else $error("write to input location did not toggle outputs");

	property p_bit_set;
		@(posedge clk) disable iff (srst)
		io_req.bset && !io_req.we && io_req.addr == GP_DIR_ADDR
			|=> direction_ff == (($past(direction_ff) | (8'h01 << $past(io_req.bidx)))
				& 8'(2**NPIN - 1));
	endproperty
	a_bit_set: assert property (p_bit_set)
		else $error("bit set disturbed other direction bits");

	property p_loopback;
		@(posedge clk) disable iff (srst)
		pin_oe != '0
			|=> ((in_sync ^ $past(pin_o)) & $past(pin_oe)) == '0;
	endproperty
	a_loopback: assert property (p_loopback)
		else $error("driven level not in input bit one clock later");

endmodule // gp_port

// ### hdl/gp_sync.sv
// Purpose: input synchroniser, a falling-edge hold stage then a register
// Assumes: clk is the system clock, d comes straight from the pins
// Notes: the first stage is read by the second stage only
`timescale 1ns/1ns
module gp_sync
	import gp_pkg::*;
#(
	parameter int unsigned W = GP_NPIN
) (
	input  wire logic         clk,
	input  wire logic         srst,
	input  wire logic [W-1:0] d,
	output logic [W-1:0]      q
);

	logic [W-1:0] hold_ff;
	logic [W-1:0] q_ff;

	// takes the pin at each falling edge, holds until the next falling edge
	always_ff @(negedge clk) begin
		if (srst) begin
			hold_ff <= '0;
		end else begin
			hold_ff <= d;
		end
	end

	// input bit taken at the following rising edge
	always_ff @(posedge clk) begin
		if (srst) begin
			q_ff <= '0;
		end else begin
			q_ff <= hold_ff;
		end
	end

	assign q = q_ff;

	// a level held over two rising edges shows at the register
	property p_sync_level;
		@(posedge clk) disable iff (srst)
		!$past(srst) && $stable(d) && d == $past(d, 2) |-> q == d;
	endproperty
	a_sync_level: assert property (p_sync_level)
		else $error("synchroniser output lags a steady pin");

endmodule // gp_sync

// ### shared/gp_pkg.sv
// Purpose: shared constants and carrier types for the six-pin port
// Assumes: 6-bit I/O address space, 8-bit data, one system clock
// Notes: offsets are I/O-space addresses, not byte addresses
package gp_pkg;

	// port geometry
	localparam int unsigned GP_NPIN     = 6;
	localparam int unsigned GP_ADDR_W   = 6;
	localparam int unsigned GP_DATA_W   = 8;

	// I/O-space locations
	localparam logic [5:0] GP_PCM_ADDR  = 6'h15;
	localparam logic [5:0] GP_IN_ADDR   = 6'h16;
	localparam logic [5:0] GP_DIR_ADDR  = 6'h17;
	localparam logic [5:0] GP_OUT_ADDR  = 6'h18;
	localparam logic [5:0] GP_CCR_ADDR  = 6'h35;
	localparam logic [5:0] GP_IRQF_ADDR = 6'h3A;
	localparam logic [5:0] GP_GIMR_ADDR = 6'h3B;
	// single-bit operations reach only addresses below this
	localparam logic [5:0] GP_BITOP_LIM = 6'h20;

	// field positions
	localparam int unsigned GP_PCIE_BIT = 5;
	localparam int unsigned GP_PCF_BIT  = 5;
	localparam int unsigned GP_PUO_BIT  = 6;

	// reset values
	localparam logic [7:0] GP_PCM_RST   = 8'h00;
	localparam logic [7:0] GP_DIR_RST   = 8'h00;
	localparam logic [7:0] GP_OUT_RST   = 8'h00;
	localparam logic       GP_PUO_RST   = 1'b0;
	localparam logic       GP_PCIE_RST  = 1'b0;
	localparam logic       GP_PCF_RST   = 1'b0;
	localparam logic [7:0] GP_RD_RST    = 8'h00;

	// one I/O access from the core, all fields valid in one cycle
	typedef struct packed {
		logic       we;    // full-byte write
		logic       re;    // full-byte read
		logic       bset;  // single-bit set
		logic       bclr;  // single-bit clear
		logic [5:0] addr;
		logic [2:0] bidx;
		logic [7:0] wdata;
	} gp_io_req_t;

endpackage

// ### verification/gp_pin_model.sv
// Purpose: outside circuitry hanging on the six port pads
// Assumes: bench chooses which pads it drives from outside and to what level
// Notes: an undriven pad without pull-up wanders every cycle, never holds
`timescale 1ns/1ns
module gp_pin_model
	import gp_pkg::*;
(
	input  wire logic               clk,
	input  wire logic [GP_NPIN-1:0] pin_o,
	input  wire logic [GP_NPIN-1:0] pin_oe,
	input  wire logic [GP_NPIN-1:0] pin_pu,
	input  wire logic [GP_NPIN-1:0] ext_en,
	input  wire logic [GP_NPIN-1:0] ext_val,
	output logic [GP_NPIN-1:0]      pin_i
);
	logic [GP_NPIN-1:0] float_ff = '0;

	// floating level flips each cycle so no stale value passes for valid
	always @(posedge clk) begin
		float_ff <= ~float_ff;
	end

	// pad level: port driver, then outside source, then pull-up, then float
	always_comb begin
		for (int i = 0; i < GP_NPIN; i++) begin
			if (pin_oe[i]) begin
				pin_i[i] = pin_o[i];
			end else if (ext_en[i]) begin
				pin_i[i] = ext_val[i];
			end else if (pin_pu[i]) begin
				pin_i[i] = 1'b1;
			end else begin
				pin_i[i] = float_ff[i];
			end
		end
	end
endmodule // gp_pin_model

// ### verification/tb_gpio_port_with_pin_change_irq.sv
// Purpose: self-checking bench for the six-pin port and its change flag
// Assumes: one I/O access at a time, inputs moved at rising edges
// Notes: pin model stands in for the board outside the pads
`timescale 1ns/1ns
module tb_gpio_port_with_pin_change_irq
	import gp_pkg::*;
;
	logic       clk           = 1'b0;
	logic       srst          = 1'b1;
	gp_io_req_t io_req        = '0;
	logic [7:0] io_rdata;
	logic       global_irq_en = 1'b0;
	logic       irq_ack       = 1'b0;
	logic       irq_req;
	logic [5:0] pin_i;
	logic [5:0] pin_o;
	logic [5:0] pin_oe;
	logic [5:0] pin_pu;
	logic [5:0] ext_en        = 6'h30;
	logic [5:0] ext_val       = 6'h20;
	int         n_mismatch    = 0;
	int         checks_done   = 0;

	// 100 ns system clock
	always #50 clk = ~clk;

	gp_port #(.NPIN(GP_NPIN)) dut_u (.clk(clk), .srst(srst), .io_req(io_req),
		.io_rdata(io_rdata), .global_irq_en(global_irq_en), .irq_ack(irq_ack),
		.irq_req(irq_req), .pin_i(pin_i), .pin_o(pin_o), .pin_oe(pin_oe), .pin_pu(pin_pu));
	gp_pin_model pin_u (.clk(clk), .pin_o(pin_o), .pin_oe(pin_oe), .pin_pu(pin_pu),
		.ext_en(ext_en), .ext_val(ext_val), .pin_i(pin_i));

	// compare and count
	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("ERROR at %0t: seen 0x%h expected 0x%h", $time, seen, exp);
		end
	endtask

	// verdict and stop
	task automatic end_sim;
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// one write-type access, held for exactly one taking edge
	task automatic acc(input logic w, input logic bs, input logic bc, input logic [5:0] a,
		input logic [2:0] b, input logic [7:0] d);
		@(posedge clk);
		io_req <= '{we: w, re: 1'b0, bset: bs, bclr: bc, addr: a, bidx: b, wdata: d};
		@(posedge clk);
		io_req <= '0;
		#1;
	endtask

	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		acc(1'b1, 1'b0, 1'b0, a, 3'h0, d);
	endtask

	// read, data taken a cycle after the request edge
	task automatic rd(input logic [5:0] a, input logic [7:0] exp);
		@(posedge clk);
		io_req <= '{we: 1'b0, re: 1'b1, bset: 1'b0, bclr: 1'b0, addr: a, bidx: 3'h0, wdata: 8'h00};
		@(posedge clk);
		io_req <= '0;
		@(posedge clk);
		#1;
		chk(io_rdata, exp);
	endtask

	// bounded wait for the request line
	task automatic wait_irq(input logic exp);
		int k;
		k = 0;
		while (irq_req !== exp && k < 10) begin
			@(posedge clk);
			#1;
			k++;
		end
		chk({7'h00, irq_req}, {7'h00, exp});
		if (irq_req !== exp) end_sim();
	endtask

	// hang guard
	initial begin
		repeat (20000) @(posedge clk);
		chk(8'h00, 8'h01);
		end_sim();
	end

	// main sequence
	initial begin
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		rd(GP_PCM_ADDR, 8'h00);
		rd(GP_DIR_ADDR, 8'h00);
		rd(GP_OUT_ADDR, 8'h00);
		rd(GP_CCR_ADDR, 8'h00);
		rd(6'h20, 8'h00);
		wr(GP_PCM_ADDR, 8'hFF);
		rd(GP_PCM_ADDR, 8'h3F);
		wr(GP_PCM_ADDR, 8'h00);
		$display("test reset_and_mask done");
		// pull-up step first, then drive
		wr(GP_OUT_ADDR, 8'h13);
		chk({2'h0, pin_pu}, 8'h13);
		wr(GP_DIR_ADDR, 8'h0F);
		chk({2'h0, pin_oe}, 8'h0F);
		chk({2'h0, pin_o}, 8'h13);
		chk({2'h0, pin_pu}, 8'h10);
		rd(GP_OUT_ADDR, 8'h13);
		rd(GP_IN_ADDR, 8'h23);
		wr(GP_CCR_ADDR, 8'h40);
		chk({2'h0, pin_pu}, 8'h00);
		rd(GP_CCR_ADDR, 8'h40);
		wr(GP_CCR_ADDR, 8'h00);
		$display("test direction_and_pullup done");
		// toggles through the input location
		wr(GP_IN_ADDR, 8'h21);
		chk({2'h0, pin_o}, 8'h32);
		acc(1'b0, 1'b1, 1'b0, GP_IN_ADDR, 3'h1, 8'h00);
		chk({2'h0, pin_o}, 8'h30);
		acc(1'b0, 1'b0, 1'b1, GP_IN_ADDR, 3'h4, 8'h00);
		chk({2'h0, pin_o}, 8'h30);
		chk({2'h0, pin_pu}, 8'h30);
		acc(1'b0, 1'b1, 1'b0, GP_DIR_ADDR, 3'h5, 8'h00);
		acc(1'b0, 1'b0, 1'b1, GP_DIR_ADDR, 3'h0, 8'h00);
		rd(GP_DIR_ADDR, 8'h2E);
		// bit clear on the output register, bit set above the bit range ignored
		acc(1'b0, 1'b0, 1'b1, GP_OUT_ADDR, 3'h4, 8'h00);
		chk({2'h0, pin_o}, 8'h20);
		chk({2'h0, pin_pu}, 8'h00);
		acc(1'b0, 1'b1, 1'b0, GP_CCR_ADDR, 3'h6, 8'h00);
		rd(GP_CCR_ADDR, 8'h00);
		$display("test toggle_and_bitops done");
		// pin 0 input from outside, watched for changes
		@(posedge clk);
		ext_en <= 6'h11;
		ext_val <= 6'h00;
		global_irq_en <= 1'b1;
		wr(GP_PCM_ADDR, 8'h01);
		wr(GP_GIMR_ADDR, 8'h20);
		rd(GP_GIMR_ADDR, 8'h20);
		wr(GP_IRQF_ADDR, 8'h20);
		rd(GP_IRQF_ADDR, 8'h00);
		@(posedge clk);
		ext_val <= 6'h01;
		wait_irq(1'b1);
		rd(GP_IRQF_ADDR, 8'h20);
		@(posedge clk);
		irq_ack <= 1'b1;
		@(posedge clk);
		irq_ack <= 1'b0;
		#1;
		chk({7'h00, irq_req}, 8'h00);
		@(posedge clk);
		global_irq_en <= 1'b0;
		ext_val <= 6'h00;
		repeat (4) @(posedge clk);
		#1;
		chk({7'h00, irq_req}, 8'h00);
		rd(GP_IRQF_ADDR, 8'h20);
		wr(GP_IRQF_ADDR, 8'h20);
		rd(GP_IRQF_ADDR, 8'h00);
		@(posedge clk);
		ext_val <= 6'h10;
		repeat (4) @(posedge clk);
		rd(GP_IRQF_ADDR, 8'h00);
		$display("test change_flag done");
		// output pin toggled by software raises the flag too
		@(posedge clk);
		global_irq_en <= 1'b1;
		wr(GP_PCM_ADDR, 8'h20);
		wr(GP_IN_ADDR, 8'h20);
		wait_irq(1'b1);
		// reset in mid-run drops the drivers before any edge
		@(posedge clk);
		srst <= 1'b1;
		#1;
		chk({2'h0, pin_oe}, 8'h00);
		chk({2'h0, pin_pu}, 8'h00);
		repeat (2) @(posedge clk);
		srst <= 1'b0;
		rd(GP_DIR_ADDR, 8'h00);
		rd(GP_PCM_ADDR, 8'h00);
		chk({7'h00, irq_req}, 8'h00);
		$display("test software_change_and_reset done");
		end_sim();
	end
endmodule // tb_gpio_port_with_pin_change_irq
